// file: pts_bank.sv
// telemetry readings, status bytes and output on/off control
// ------------------------------------------------------------
// Summary of operation
// - current reading is linear, exponent -4 in high byte bits 7:3.
// - current mantissa is eleven bits with msb always zero.
// - current below 1.65 A reads as zero.
// - samples taken while the converter sinks current count as zero in the average.
// - reported current comes from an averaged measurement.
// - read-only offset correction, exponent -4, eleven-bit signed mantissa.
// - unsigned gain; current = raw * gain / 8192 plus offset.
// - current is temperature compensated before being reported.
// - temperature reading is linear with exponent -2.
// - status word high byte: vout 15, iout 14, input 13, pg_n 11.
// - status low byte: off 6, ov 5, oc 4, uv 3, temp 2, comm 1.
// - unsupported status bits stay zero; status bits other than off follow their sources live and are not cleared by reset.
// - vout status implements only bit 7 overvoltage fault.
// - iout status: fault bit 7, warning bit 5.
// - input status: ov bit 7, uv bit 4, off-low-input bit 3.
// - temperature status: fault bit 7, warning bit 6.
// - comm status: bad command 7, bad data 6, pec failure 5.
// - on/off command code 0x01, immediate on/off and act-on-fault margins.
// - on/off bits 6,3,2,1,0 are read-only at factory values.
// - on/off bit 7 zero disables output, one enables it.
// ------------------------------------------------------------
`timescale 1ns/1ps
module pts_bank
    import pts_pkg::*;
#(
    parameter int AVG_LOG2 = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // command port from the bus engine
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_wdata,
    output logic [15:0] rd_data,
    output logic rd_valid,
    // measurement front end, same clock
    input wire logic sample_valid,
    input wire logic [11:0] iout_raw,
    input wire logic iout_sinking,
    input wire logic [10:0] temp_raw,
    // factory trim, constant after power-up
    input wire logic [15:0] cal_gain,
    input wire logic [10:0] cal_offset,
    // detailed fault sources, same clock
    input wire logic vout_ov_fault,
    input wire logic iout_oc_fault,
    input wire logic iout_oc_warn,
    input wire logic vin_ov_fault,
    input wire logic vin_uv_fault,
    input wire logic off_low_vin,
    input wire logic ot_fault,
    input wire logic ot_warn,
    input wire logic bad_command,
    input wire logic bad_data,
    input wire logic pec_failed,
    input wire logic power_good,
    // output control
    output logic output_enable
);
    // ------------------------------------------------------------
    // correction arithmetic
    // ------------------------------------------------------------
    function automatic logic [10:0] correct(input logic [11:0] raw, input logic [15:0] gain,
                                            input logic [10:0] offs, input logic [10:0] temp);
        logic [28:0] prod;
        logic signed [18:0] val;
        logic signed [18:0] comp;
        logic signed [37:0] tprod;
        prod = {17'h00000, raw} * {13'h0000, gain};
        val = $signed({3'h0, prod[GAIN_SHIFT +: 16]}) + $signed({{8{offs[10]}}, offs});
        // small linear tempco so copper resistance rise is not read as load
        // full-width product, a 19-bit one wraps at high load and temperature
        tprod = val * $signed({{8{temp[10]}}, temp});
        comp = val - 19'(tprod >>> TEMP_COEF_SHIFT);
        if (comp < 0) begin
            correct = 11'h000;
        end else if (comp > 19'sh003ff) begin
            correct = 11'h3ff;
        end else begin
            correct = comp[10:0];
        end
    endfunction : correct

    function automatic logic [15:0] linear(input logic [4:0] e, input logic [10:0] m);
        linear = {e, m};
    endfunction : linear

    pts_state_t s_reg;
    pts_state_t s_next;
    logic [7:0] st_vout;
    logic [7:0] st_iout;
    logic [7:0] st_input;
    logic [7:0] st_temp;
    logic [7:0] st_comm;
    logic [15:0] st_word;
    logic [10:0] iout_corr;
    logic [15:0] acc_sum;

    // ------------------------------------------------------------
    // status bytes
    // ------------------------------------------------------------
    always_comb begin
        st_vout = 8'h00;
        st_vout[7] = vout_ov_fault;
        st_iout = 8'h00;
        st_iout[7] = iout_oc_fault;
        st_iout[5] = iout_oc_warn;
        st_input = 8'h00;
        st_input[7] = vin_ov_fault;
        st_input[4] = vin_uv_fault;
        st_input[3] = off_low_vin;
        st_temp = 8'h00;
        st_temp[7] = ot_fault;
        st_temp[6] = ot_warn;
        st_comm = 8'h00;
        st_comm[7] = bad_command;
        st_comm[6] = bad_data;
        st_comm[5] = pec_failed;
        st_word = 16'h0000;
        st_word[SW_VOUT] = |st_vout;
        st_word[SW_IOUT] = |st_iout;
        st_word[SW_INPUT] = |st_input;
        st_word[SW_PG_N] = ~power_good;
        st_word[SW_OFF] = ~s_reg.output_enable | off_low_vin;
        st_word[SW_OV] = vout_ov_fault;
        st_word[SW_OC] = iout_oc_fault;
        st_word[SW_UV] = vin_uv_fault;
        st_word[SW_TEMP] = |st_temp;
        st_word[SW_COMM] = |st_comm;
    end

    // ------------------------------------------------------------
    // state update
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.rd_valid = 1'b0;
        // sinking samples count as zero so they drag the average down
        acc_sum = s_reg.acc + (iout_sinking ? 16'h0000 : {4'h0, iout_raw});
        // the closing sample belongs to its own window
        iout_corr = correct(acc_sum[AVG_LOG2 +: 12], cal_gain, cal_offset, temp_raw);
        if (sample_valid) begin
            s_next.acc = acc_sum;
            s_next.avg_cnt = s_reg.avg_cnt + 5'h01;
            if (s_reg.avg_cnt == 5'((1 << AVG_LOG2) - 1)) begin
                s_next.acc = 16'h0000;
                s_next.avg_cnt = 5'h00;
                // correction happens once per window, off the read path
                s_next.iout_avg = (iout_corr < BLANK_CODE) ? 11'h000 : iout_corr;
            end
        end
        if (cmd_valid && cmd_write && cmd_code == CMD_ON_OFF) begin
            s_next.on_off = (cmd_wdata & ON_OFF_WR_MASK) | (ON_OFF_RESET & ~ON_OFF_WR_MASK);
        end
        if (cmd_valid && !cmd_write) begin
            s_next.rd_valid = 1'b1;
            case (cmd_code)
                CMD_ON_OFF: s_next.rd_data = {8'h00, s_reg.on_off};
                CMD_IOUT: s_next.rd_data = linear(EXP_IOUT, {1'b0, s_reg.iout_avg[9:0]});
                CMD_TEMP: s_next.rd_data = linear(EXP_TEMP, temp_raw);
                CMD_CAL_OFFSET: s_next.rd_data = linear(EXP_IOUT, cal_offset);
                CMD_CAL_GAIN: s_next.rd_data = cal_gain;
                CMD_STATUS_WORD: s_next.rd_data = st_word;
                CMD_OUTPUT_VOLTAGE_STATUS: s_next.rd_data = {8'h00, st_vout};
                CMD_STATUS_IOUT: s_next.rd_data = {8'h00, st_iout};
                CMD_STATUS_INPUT: s_next.rd_data = {8'h00, st_input};
                CMD_STATUS_TEMP: s_next.rd_data = {8'h00, st_temp};
                CMD_STATUS_COMM: s_next.rd_data = {8'h00, st_comm};
                default: s_next.rd_data = 16'h0000;
            endcase
        end
        s_next.output_enable = s_next.on_off[ON_BIT];
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_reg <= '0;
            s_reg.on_off <= ON_OFF_RESET;
            s_reg.output_enable <= ON_OFF_RESET[ON_BIT];
        end else begin
            s_reg <= s_next;
        end
    end

    assign rd_data = s_reg.rd_data;
    assign rd_valid = s_reg.rd_valid;
    assign output_enable = s_reg.output_enable;
endmodule : pts_bank

// file: pts_pkg.sv
// constants and types for the telemetry and status register bank
package pts_pkg;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_ON_OFF = 8'h01;
    localparam logic [7:0] CMD_IOUT = 8'h8c;
    localparam logic [7:0] CMD_TEMP = 8'h8d;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS = 8'h7a;
    localparam logic [7:0] CMD_STATUS_IOUT = 8'h7b;
    localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c;
    localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;
    localparam logic [7:0] CMD_STATUS_COMM = 8'h7e;
    localparam logic [7:0] CMD_CAL_OFFSET = 8'hd0;
    localparam logic [7:0] CMD_CAL_GAIN = 8'hd1;
    // ------------------------------------------------------------
    // linear format
    // ------------------------------------------------------------
    localparam logic [4:0] EXP_IOUT = 5'h1c;
    localparam logic [4:0] EXP_TEMP = 5'h1e;
    localparam int GAIN_SHIFT = 13;
    localparam int BLANK_MA = 1650;
    localparam int STEP_UA = 62500;
    localparam logic [10:0] BLANK_CODE = 11'(((BLANK_MA * 1000) + STEP_UA - 1) / STEP_UA);
    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] ON_OFF_RESET = 8'h80;
    localparam logic [7:0] ON_OFF_WR_MASK = 8'hb0;
    localparam int ON_BIT = 7;
    localparam logic [15:0] GAIN_RESET = 16'h2000;
    localparam logic [10:0] OFFSET_RESET = 11'h000;
    localparam int TEMP_COEF_SHIFT = 10;
    localparam int SW_VOUT = 15;
    localparam int SW_IOUT = 14;
    localparam int SW_INPUT = 13;
    localparam int SW_PG_N = 11;
    localparam int SW_OFF = 6;
    localparam int SW_OV = 5;
    localparam int SW_OC = 4;
    localparam int SW_UV = 3;
    localparam int SW_TEMP = 2;
    localparam int SW_COMM = 1;

    typedef struct packed {
        logic [7:0] on_off;
        logic [15:0] acc;
        logic [4:0] avg_cnt;
        logic [10:0] iout_avg;
        logic [15:0] rd_data;
        logic rd_valid;
        logic output_enable;
    } pts_state_t;
endpackage : pts_pkg

// file: pts_monitor.sv
// port assertions for the telemetry bank
`timescale 1ns/1ps
module pts_monitor
    import pts_pkg::*;
(
    // clock, reset, command port
    input wire logic core_clk, srst, cmd_valid, cmd_write,
    input wire logic [7:0] cmd_code, cmd_wdata,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid, output_enable,
    // fault sources
    input wire logic vout_ov_fault, iout_oc_fault, iout_oc_warn, ot_fault, ot_warn,
    input wire logic bad_command, bad_data, pec_failed
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_rd(logic [7:0] c);
        cmd_valid && !cmd_write && cmd_code == c;
    endsequence
    AST_RD_ANSWER: assert property (cmd_valid && !cmd_write |=> rd_valid)
        else $error("read not answered");
    AST_ON_BIT: assert property (cmd_valid && cmd_write && cmd_code == CMD_ON_OFF |=> output_enable == $past(cmd_wdata[7]))
        else $error("output enable wrong");
    AST_ONOFF_RO: assert property (s_rd(CMD_ON_OFF) |=> (rd_data & 16'hff4f) == 16'h0000)
        else $error("on/off fixed bits set");
    AST_IOUT_FMT: assert property (s_rd(CMD_IOUT) |=> rd_data[15:10] == {EXP_IOUT, 1'b0})
        else $error("current format wrong");
    AST_TEMP_FMT: assert property (s_rd(CMD_TEMP) |=> rd_data[15:11] == EXP_TEMP)
        else $error("temperature exponent wrong");
    AST_VOUT_ST: assert property (s_rd(CMD_OUTPUT_VOLTAGE_STATUS) |=> rd_data == {8'h00, $past(vout_ov_fault), 7'h00})
        else $error("vout status wrong");
    AST_IOUT_ST: assert property (s_rd(CMD_STATUS_IOUT) |=> rd_data == {8'h00, $past(iout_oc_fault), 1'b0, $past(iout_oc_warn), 5'h00})
        else $error("iout status wrong");
    AST_TEMP_ST: assert property (s_rd(CMD_STATUS_TEMP) |=> rd_data == {8'h00, $past(ot_fault), $past(ot_warn), 6'h00})
        else $error("temp status wrong");
    AST_COMM_ST: assert property (s_rd(CMD_STATUS_COMM) |=> rd_data == {8'h00, $past(bad_command), $past(bad_data), $past(pec_failed), 5'h00})
        else $error("comm status wrong");
endmodule : pts_monitor
bind pts_bank pts_monitor u_pts_monitor (.core_clk, .srst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
    .rd_data, .rd_valid, .output_enable, .vout_ov_fault, .iout_oc_fault, .iout_oc_warn, .ot_fault, .ot_warn,
    .bad_command, .bad_data, .pec_failed);

// file: pts_host.sv
// host model driving the bank's command port
`timescale 1ns/1ps
module pts_host (
    // clock
    input wire logic core_clk,
    // command port
    output logic cmd_valid = 1'b0,
    output logic cmd_write = 1'b0,
    output logic [7:0] cmd_code = 8'h00,
    output logic [7:0] cmd_wdata = 8'h00,
    // answer
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    task automatic xfer(input logic w, input logic [7:0] c, d, output logic [15:0] q, output logic v);
        repeat ($urandom_range(2)) @(posedge core_clk);
        @(posedge core_clk);
        #1;
        {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b1, w, c, d};
        @(posedge core_clk);
        #1;
        // released lines show garbage, not the last value
        {cmd_valid, cmd_code, cmd_wdata} = {1'b0, ~c, ~d};
        q = rd_data;
        v = rd_valid;
    endtask : xfer
endmodule : pts_host

// file: pts_bank_tb.sv
// self-checking bench for the telemetry bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module pts_bank_tb
    import pts_pkg::*;
;
    logic core_clk = 1'b0, srst = 1'b1, sample_valid = 1'b0, iout_sinking = 1'b0, en = 1'b1;
    logic cmd_valid, cmd_write, rd_valid, output_enable, v;
    logic [7:0] cmd_code, cmd_wdata, w;
    logic [15:0] rd_data, q, cal_gain = 16'h2000;
    logic [11:0] iout_raw = 12'h000, flt = 12'h001;
    logic [10:0] temp_raw = 11'h000, cal_offset = 11'h000;
    int error_cnt = 0, samples_checked = 0;
    always #2 core_clk = ~core_clk;
    pts_host u_pts_host (.core_clk, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .rd_data, .rd_valid);
    pts_bank #(.AVG_LOG2(1)) u_pts_bank (.core_clk, .srst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
        .rd_data, .rd_valid, .sample_valid, .iout_raw, .iout_sinking, .temp_raw, .cal_gain, .cal_offset,
        .vout_ov_fault(flt[11]), .iout_oc_fault(flt[10]), .iout_oc_warn(flt[9]), .vin_ov_fault(flt[8]),
        .vin_uv_fault(flt[7]), .off_low_vin(flt[6]), .ot_fault(flt[5]), .ot_warn(flt[4]),
        .bad_command(flt[3]), .bad_data(flt[2]), .pec_failed(flt[1]), .power_good(flt[0]), .output_enable);
    function automatic logic [15:0] exp_st(logic [7:0] c, logic [11:0] f, logic e);
        case (c)
            CMD_OUTPUT_VOLTAGE_STATUS: return {8'h00, f[11], 7'h00};
            CMD_STATUS_IOUT: return {8'h00, f[10], 1'b0, f[9], 5'h00};
            CMD_STATUS_INPUT: return {8'h00, f[8], 2'b00, f[7:6], 3'b000};
            CMD_STATUS_TEMP: return {8'h00, f[5:4], 6'h00};
            CMD_STATUS_COMM: return {8'h00, f[3:1], 5'h00};
            default: return {f[11], |f[10:9], |f[8:6], 1'b0, ~f[0], 4'h0, ~e | f[6], f[11], f[10], f[7],
                |f[5:4], |f[3:1], 1'b0};
        endcase
    endfunction : exp_st
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        u_pts_host.xfer(1'b0, c, 8'h00, q, v);
        `CHK("rd_valid", 1'b1, v)
        `CHK("rd_data", e, q)
    endtask : rd
    // two samples fill the shortened averaging window
    task automatic cur(logic [11:0] a, b, logic s, logic [15:0] g, logic [10:0] o, t, e);
        {iout_sinking, cal_gain, cal_offset, temp_raw} = {s, g, o, t};
        @(posedge core_clk);
        #1;
        {sample_valid, iout_raw} = {1'b1, a};
        @(posedge core_clk);
        #1;
        iout_raw = b;
        @(posedge core_clk);
        #1;
        sample_valid = 1'b0;
        rd(CMD_IOUT, {EXP_IOUT, e});
    endtask : cur
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    initial begin
        #20000;
        error_cnt++;
        test_done;
    end
    initial begin
        void'($urandom(32'h2d46a7e3));
        repeat (4) @(posedge core_clk);
        #1;
        srst = 1'b0;
        `CHK("output_enable", 1'b1, output_enable)
        rd(CMD_ON_OFF, 16'h0080);
        rd(8'h55, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            for (int k = 0; k < 6; k++) rd(8'h79 + 8'(k), exp_st(8'h79 + 8'(k), flt, en));
            flt = 12'($urandom);
            w = (i == 1) ? 8'hff : 8'($urandom);
            u_pts_host.xfer(1'b1, CMD_ON_OFF, w, q, v);
            en = w[7];
            `CHK("wr_answer", 1'b0, v)
            `CHK("output_enable", en, output_enable)
            rd(CMD_ON_OFF, {8'h00, w & 8'hb0});
        end
        cur(100, 100, 0, 16'h2000, 0, 0, 100);
        cur(40, 60, 0, 16'h2000, 0, 0, 50);
        cur(26, 26, 0, 16'h2000, 0, 0, 0);
        cur(27, 27, 0, 16'h2000, 0, 0, 27);
        cur(300, 300, 1, 16'h2000, 0, 0, 0);
        cur(2000, 2000, 0, 16'h2000, 0, 0, 1023);
        cur(30, 30, 0, 16'h4000, 0, 0, 60);
        cur(30, 30, 0, 16'h2000, 5, 0, 35);
        cur(160, 160, 0, 16'h2000, 0, 64, 150);
        cur(1000, 1000, 0, 16'h2000, 0, 512, 500);
        {cal_gain, cal_offset, temp_raw} = {16'($urandom), 11'($urandom), 11'($urandom)};
        rd(CMD_CAL_GAIN, cal_gain);
        rd(CMD_CAL_OFFSET, {EXP_IOUT, cal_offset});
        rd(CMD_TEMP, {EXP_TEMP, temp_raw});
        test_done;
    end
endmodule : pts_bank_tb
